// [hw/timer_timebase_interrupt_ctrl.v]
// Interrupt control: flags, enables, priority call request, AHB-Lite regs
// Function
// - Timer interrupt needs master enable, timer enable and timer flag.
// - Timer overflow sets that timer's request flag.
// - Servicing a timer clears its flag and the master enable.
// - Time-base overflow sets its flag; needs master and time-base enable.
// - Servicing time base clears its flag and the master enable.
// - Call requested only while stack not full; otherwise request waits.
// - Flags stay set regardless of enable until serviced or cleared.
// - Every source can wake the core from idle or sleep.
// - Entry pushes only the program counter, nothing else.
// - Three-timer primary register layout, bit 7 reads zero.
// - Three-timer secondary: T2 enable 0, TB enable 2, T2 flag 4, TB flag 6.
// - Three-timer secondary odd bits always read zero.
// - Reserved-vector two-timer secondary: TB flag 5, TB enable 1.
// - Plain two-timer secondary: TB flag 4, TB enable 0.
// - Fixed priority external, T0, T1, T2, time base with set vectors.
// - Branch 2 instruction cycles after request, 3 after wake-up.
// - Sample between third-phase edges; software may re-enable for nesting.
`include "intc_regs.vh"
module timer_timebase_interrupt_ctrl #(
  parameter VARIANT = 0
) (
  input  wire        ref_clk_i,
  input  wire        nrst_i,
  input  wire        hsel_i,
  input  wire [31:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire [2:0]  hsize_i,
  input  wire [31:0] hwdata_i,
  input  wire        hready_i,
  output wire [31:0] hrdata_o,
  output wire        hreadyout_o,
  output wire        hresp_o,
  input  wire        ext_edge_i,
  input  wire [2:0]  timer_ovf_i,
  input  wire        timebase_ovf_i,
  input  wire        third_clock_phase_i,
  input  wire        stack_full_i,
  input  wire        core_sleep_i,
  output wire        call_req_o,
  output wire [7:0]  call_vector_o,
  output wire        push_pc_o,
  output wire        wake_o,
  output wire        irq_o
);

  // ----------------------------------------
  // Constants and functions
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;
  localparam [4:0] IMPL_MASK = (VARIANT == 0) ? 5'h1F : 5'h17;

  function hit;
    input [`DEC_W-1:0] addr;
    input [`DEC_W-1:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  function [7:0] sec_pack;
    input [4:0] fl;
    input [4:0] en;
    begin
      sec_pack = 8'h00;
      case (VARIANT)
        0: begin
          sec_pack[`SEC3_T2_EN] = en[`SRC_T2];
          sec_pack[`SEC3_TB_EN] = en[`SRC_TB];
          sec_pack[`SEC3_T2_F]  = fl[`SRC_T2];
          sec_pack[`SEC3_TB_F]  = fl[`SRC_TB];
        end
        1: begin
          sec_pack[`SECR_TB_EN] = en[`SRC_TB];
          sec_pack[`SECR_TB_F]  = fl[`SRC_TB];
        end
        default: begin
          sec_pack[`SECP_TB_EN] = en[`SRC_TB];
          sec_pack[`SECP_TB_F]  = fl[`SRC_TB];
        end
      endcase
    end
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  wire rst_n;

  reset_sync u_rst (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .nrst_sync_o (rst_n)
  );

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg        emi_reg;
  reg [4:0]  flag_reg;
  reg [4:0]  en_reg;
  reg [`EVT_N-1:0] evt_stat_reg;
  reg [`EVT_N-1:0] evt_en_reg;
  reg        state_reg;
  reg [1:0]  wait_cnt_reg;
  reg [7:0]  vec_reg;
  reg        call_req_reg;
  reg        push_pc_reg;
  reg        wake_reg;
  reg        irq_reg;
  reg [31:0] hrdata_reg;
  reg        hreadyout_reg;
  reg        hresp_reg;
  reg        wr_pend_reg;
  reg [`DEC_W-1:0] wr_addr_reg;

  reg        emi_next;
  reg [4:0]  flag_next;
  reg [4:0]  en_next;
  reg [`EVT_N-1:0] evt_set;
  reg [`EVT_N-1:0] evt_stat_next;
  reg [31:0] rd_next;

  wire [4:0] hw_set;
  wire [4:0] cand;
  wire       pick_any;
  wire [2:0] pick_idx;
  wire [7:0] pick_vec;
  wire       addr_ok;
  wire [7:0] wb;
  wire [`DEC_W-1:0] ra;
  wire       sample;
  wire       take;
  wire       stall;

  // ----------------------------------------
  // Request qualification
  // ----------------------------------------
  // timer overflow raises flag
  assign hw_set = {timebase_ovf_i, timer_ovf_i, ext_edge_i} & IMPL_MASK;

  // flag, own enable and master enable
  assign cand = emi_reg ? (flag_reg & en_reg & IMPL_MASK) : 5'h00;

  irq_priority #(
    .VARIANT (VARIANT)
  ) u_prio (
    .req_i    (cand),
    .any_o    (pick_any),
    .idx_o    (pick_idx),
    .vector_o (pick_vec)
  );

  assign sample = third_clock_phase_i && (state_reg == ST_IDLE) && pick_any;
  assign take   = sample && !stack_full_i;
  assign stall  = sample && stack_full_i;

  // ----------------------------------------
  // AHB-Lite decode
  // ----------------------------------------
  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign ra      = haddr_i[`DEC_W-1:0];
  assign wb      = hwdata_i[7:0];

  always @* begin
    rd_next = 32'h0000_0000;
    if (hit(ra, `OFF_PRIMARY)) begin
      rd_next[`PRI_EMI]    = emi_reg;
      rd_next[`PRI_EXT_EN] = en_reg[`SRC_EXT];
      rd_next[`PRI_T0_EN]  = en_reg[`SRC_T0];
      rd_next[`PRI_T1_EN]  = en_reg[`SRC_T1];
      rd_next[`PRI_EXT_F]  = flag_reg[`SRC_EXT];
      rd_next[`PRI_T0_F]   = flag_reg[`SRC_T0];
      rd_next[`PRI_T1_F]   = flag_reg[`SRC_T1];
    end else if (hit(ra, `OFF_SECONDARY)) begin
      rd_next[7:0] = sec_pack(flag_reg, en_reg);
    end else if (hit(ra, `OFF_EVT_STATUS)) begin
      rd_next[`EVT_N-1:0] = evt_stat_reg;
    end else if (hit(ra, `OFF_EVT_ENABLE)) begin
      rd_next[`EVT_N-1:0] = evt_en_reg;
    end else if (hit(ra, `OFF_CORE_STAT)) begin
      rd_next[7:0] = vec_reg;
      rd_next[8]   = state_reg;
      rd_next[9]   = stack_full_i && pick_any;
    end
  end

  // ----------------------------------------
  // Flag, enable and master enable update
  // ----------------------------------------
  always @* begin
    emi_next  = emi_reg;
    flag_next = flag_reg;
    en_next   = en_reg;
    if (wr_pend_reg && hit(wr_addr_reg, `OFF_PRIMARY)) begin
      emi_next          = wb[`PRI_EMI];
      en_next[`SRC_EXT] = wb[`PRI_EXT_EN];
      en_next[`SRC_T0]  = wb[`PRI_T0_EN];
      en_next[`SRC_T1]  = wb[`PRI_T1_EN];
      flag_next[`SRC_EXT] = wb[`PRI_EXT_F];
      flag_next[`SRC_T0]  = wb[`PRI_T0_F];
      flag_next[`SRC_T1]  = wb[`PRI_T1_F];
    end
    if (wr_pend_reg && hit(wr_addr_reg, `OFF_SECONDARY)) begin
      case (VARIANT)
        0: begin
          en_next[`SRC_T2]   = wb[`SEC3_T2_EN];
          en_next[`SRC_TB]   = wb[`SEC3_TB_EN];
          flag_next[`SRC_T2] = wb[`SEC3_T2_F];
          flag_next[`SRC_TB] = wb[`SEC3_TB_F];
        end
        1: begin
          en_next[`SRC_TB]   = wb[`SECR_TB_EN];
          flag_next[`SRC_TB] = wb[`SECR_TB_F];
        end
        default: begin
          en_next[`SRC_TB]   = wb[`SECP_TB_EN];
          flag_next[`SRC_TB] = wb[`SECP_TB_F];
        end
      endcase
    end
    if (take) begin
      // serviced flag and master enable drop
      flag_next[pick_idx] = 1'b0;
      emi_next            = 1'b0;
    end
    // only service or software clears a flag
    flag_next = (flag_next | hw_set) & IMPL_MASK;
    en_next   = en_next & IMPL_MASK;
  end

  // ----------------------------------------
  // Event status
  // ----------------------------------------
  always @* begin
    evt_set               = {`EVT_N{1'b0}};
    evt_set[`EVT_SERVICE] = take;
    evt_set[`EVT_STALL]   = stall;
    evt_set[`EVT_WAKE]    = wake_reg && !core_sleep_i;
    evt_stat_next         = evt_stat_reg;
    if (wr_pend_reg && hit(wr_addr_reg, `OFF_EVT_CLEAR)) begin
      evt_stat_next = evt_stat_reg & ~hwdata_i[`EVT_N-1:0];
    end
    // A new event beats a clear in the same cycle
    evt_stat_next = evt_stat_next | evt_set;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      emi_reg       <= 1'b0;
      flag_reg      <= 5'h00;
      en_reg        <= 5'h00;
      evt_stat_reg  <= {`EVT_N{1'b0}};
      evt_en_reg    <= {`EVT_N{1'b0}};
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      wr_pend_reg   <= 1'b0;
      wr_addr_reg   <= {`DEC_W{1'b0}};
      irq_reg       <= 1'b0;
      wake_reg      <= 1'b0;
    end else begin
      emi_reg       <= emi_next;
      flag_reg      <= flag_next;
      en_reg        <= en_next;
      evt_stat_reg  <= evt_stat_next;
      if (wr_pend_reg && hit(wr_addr_reg, `OFF_EVT_ENABLE)) begin
        evt_en_reg <= hwdata_i[`EVT_N-1:0];
      end
      // Zero wait states; unmapped reads return zero, always OKAY
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
      wr_pend_reg   <= addr_ok && hwrite_i;
      if (addr_ok) begin
        wr_addr_reg <= ra;
      end
      if (addr_ok && !hwrite_i) begin
        hrdata_reg <= rd_next;
      end
      irq_reg <= |(evt_stat_next & evt_en_reg);
      // any enabled flag wakes the core
      wake_reg <= core_sleep_i && (|(flag_next & en_next));
    end
  end

  // ----------------------------------------
  // Entry sequencer
  // ----------------------------------------
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      wait_cnt_reg <= 2'h0;
      vec_reg      <= 8'h00;
      call_req_reg <= 1'b0;
      push_pc_reg  <= 1'b0;
    end else begin
      call_req_reg <= 1'b0;
      push_pc_reg  <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (take) begin
            vec_reg   <= pick_vec;
            state_reg <= ST_WAIT;
            wait_cnt_reg <= core_sleep_i ? `ENTRY_WOKEN : `ENTRY_AWAKE;
          end
        end
        ST_WAIT: begin
          if (third_clock_phase_i) begin
            if (wait_cnt_reg == 2'h1) begin
              // only the program counter is pushed
              call_req_reg <= 1'b1;
              push_pc_reg  <= 1'b1;
              state_reg    <= ST_IDLE;
            end
            wait_cnt_reg <= wait_cnt_reg - 2'h1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata_o      = hrdata_reg;
  assign hreadyout_o   = hreadyout_reg;
  assign hresp_o       = hresp_reg;
  assign call_req_o    = call_req_reg;
  assign call_vector_o = vec_reg;
  assign push_pc_o     = push_pc_reg;
  assign wake_o        = wake_reg;
  assign irq_o         = irq_reg;

endmodule

// [hw/intc_regs.vh]
// Register map, field positions and timing constants of the interrupt block
`ifndef INTC_REGS_VH
`define INTC_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_PRIMARY    8'h00
`define OFF_SECONDARY  8'h04
`define OFF_EVT_STATUS 8'h08
`define OFF_EVT_CLEAR  8'h0C
`define OFF_EVT_ENABLE 8'h10
`define OFF_CORE_STAT  8'h14
`define DEC_W          8

// ----------------------------------------
// Source indices, also the priority order
// ----------------------------------------
`define SRC_EXT 0
`define SRC_T0  1
`define SRC_T1  2
`define SRC_T2  3
`define SRC_TB  4
`define SRC_N   5

// ----------------------------------------
// Primary control register fields
// ----------------------------------------
`define PRI_EMI    0
`define PRI_EXT_EN 1
`define PRI_T0_EN  2
`define PRI_T1_EN  3
`define PRI_EXT_F  4
`define PRI_T0_F   5
`define PRI_T1_F   6

// ----------------------------------------
// Secondary control register fields
// ----------------------------------------
`define SEC3_T2_EN 0
`define SEC3_TB_EN 2
`define SEC3_T2_F  4
`define SEC3_TB_F  6
`define SECR_TB_EN 1
`define SECR_TB_F  5
`define SECP_TB_EN 0
`define SECP_TB_F  4

// ----------------------------------------
// Variants
// ----------------------------------------
`define VAR_THREE_TMR 2'h0
`define VAR_TWO_RSVD  2'h1
`define VAR_TWO_PLAIN 2'h2

// ----------------------------------------
// Vectors
// ----------------------------------------
`define VEC_EXT     8'h04
`define VEC_T0      8'h08
`define VEC_T1      8'h0C
`define VEC_T2      8'h10
`define VEC_TB_3T   8'h18
`define VEC_TB_RSVD 8'h14
`define VEC_TB_PLN  8'h10

// ----------------------------------------
// Event status bits and entry timing
// ----------------------------------------
`define EVT_SERVICE 0
`define EVT_STALL   1
`define EVT_WAKE    2
`define EVT_N       3
`define ENTRY_AWAKE 2'h2
`define ENTRY_WOKEN 2'h3

`endif

// [hw/reset_sync.v]
// Two-stage release synchroniser for the active-low reset
module reset_sync (
  input  wire ref_clk_i,
  input  wire nrst_i,
  output wire nrst_sync_o
);
  reg stage1_reg;
  reg stage2_reg;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= 1'b1;
      stage2_reg <= stage1_reg;
    end
  end

  assign nrst_sync_o = stage2_reg;
endmodule

// [hw/irq_priority.v]
// Fixed-priority picker returning source index and call vector
`include "intc_regs.vh"
module irq_priority #(
  parameter VARIANT = 0
) (
  input  wire [4:0] req_i,
  output reg        any_o,
  output reg  [2:0] idx_o,
  output reg  [7:0] vector_o
);
  always @* begin
    any_o    = 1'b1;
    idx_o    = 3'h0;
    vector_o = `VEC_EXT;
    if (req_i[`SRC_EXT]) begin
      idx_o    = 3'h0;
      vector_o = `VEC_EXT;
    end else if (req_i[`SRC_T0]) begin
      idx_o    = 3'h1;
      vector_o = `VEC_T0;
    end else if (req_i[`SRC_T1]) begin
      idx_o    = 3'h2;
      vector_o = `VEC_T1;
    end else if (req_i[`SRC_T2]) begin
      idx_o    = 3'h3;
      vector_o = `VEC_T2;
    end else if (req_i[`SRC_TB]) begin
      idx_o = 3'h4;
      case (VARIANT)
        0:       vector_o = `VEC_TB_3T;
        1:       vector_o = `VEC_TB_RSVD;
        default: vector_o = `VEC_TB_PLN;
      endcase
    end else begin
      any_o = 1'b0;
    end
  end
endmodule

// [sim/intc_properties.sv]
// Port-level assertions for the interrupt control block
module intc_properties #(
  parameter VARIANT = 0
) (
  input logic        ref_clk_i,
  input logic        nrst_i,
  input logic        hsel_i,
  input logic [31:0] haddr_i,
  input logic [1:0]  htrans_i,
  input logic        hwrite_i,
  input logic        hready_i,
  input logic [31:0] hrdata_o,
  input logic        hreadyout_o,
  input logic        hresp_o,
  input logic        third_clock_phase_i,
  input logic        stack_full_i,
  input logic        core_sleep_i,
  input logic        call_req_o,
  input logic [7:0]  call_vector_o,
  input logic        push_pc_o,
  input logic        wake_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SEC_LIVE = (VARIANT == 0) ? 32'h0000_0055 :
    (VARIANT == 1) ? 32'h0000_0022 : 32'h0000_0011;
  logic [2:0] full_pulses;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // --------
  // Helpers
  // --------
  // Saturating: only the count below four matters
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i)
      full_pulses <= 3'h0;
    else if (!stack_full_i)
      full_pulses <= 3'h0;
    else if (third_clock_phase_i && full_pulses != 3'h7)
      full_pulses <= full_pulses + 3'h1;
  end

  sequence s_rd(logic hit);
    hsel_i && hready_i && htrans_i[1] && !hwrite_i && hit;
  endsequence
  sequence s_entry;
    call_req_o && push_pc_o;
  endsequence

  // --------
  // Properties
  // --------
  property p_push_pair; call_req_o == push_pc_o; endproperty
  property p_call_pulse; s_entry |=> !call_req_o; endproperty
  property p_call_phase; call_req_o |-> $past(third_clock_phase_i);
  endproperty
  property p_vec_legal;
    s_entry |-> call_vector_o inside {8'h04, 8'h08, 8'h0C, 8'h10,
                                      8'h14, 8'h18};
  endproperty
  property p_vec_hold; call_req_o |-> $stable(call_vector_o); endproperty
  property p_stall; call_req_o |-> full_pulses < 3'h4; endproperty
  property p_wake; wake_o |-> $past(core_sleep_i); endproperty
  property p_okay; hreadyout_o && !hresp_o; endproperty
  property p_rd_pri;
    s_rd(haddr_i[7:0] == 8'h00) |=> hrdata_o[31:7] == 25'h0;
  endproperty
  property p_rd_sec;
    s_rd(haddr_i[7:0] == 8'h04) |=> (hrdata_o & ~SEC_LIVE) == 32'h0000_0000;
  endproperty
  property p_rd_gap;
    s_rd(haddr_i[7:0] >= 8'h18) |=> hrdata_o == 32'h0000_0000;
  endproperty

  a_push_pair: assert property (p_push_pair)
    else $error("push and call differ");
  a_call_pulse: assert property (p_call_pulse)
    else $error("call longer than one cycle");
  a_call_phase: assert property (p_call_phase)
    else $error("call not after a phase pulse");
  a_vec_legal: assert property (p_vec_legal)
    else $error("call vector not legal");
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector moved at call");
  a_stall: assert property (p_stall)
    else $error("call while stack full");
  a_wake: assert property (p_wake)
    else $error("wake without sleep");
  a_okay: assert property (p_okay)
    else $error("bus not ready or not okay");
  a_rd_pri: assert property (p_rd_pri)
    else $error("primary high bits set");
  a_rd_sec: assert property (p_rd_sec)
    else $error("secondary unused bits set");
  a_rd_gap: assert property (p_rd_gap)
    else $error("unmapped read not zero");
endmodule

// [sim/core_model.sv]
// Core sequencer stand-in: phase pulses and call counting
module core_model (
  input  logic       clk_i,
  input  logic       nrst_i,
  input  logic       call_req_i,
  input  logic       push_pc_i,
  output logic       phase_o,
  output logic [7:0] calls_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cyc_reg;

  // --------
  // Instruction cycle
  // --------
  // one pulse per four clocks
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc_reg <= 2'h0;
      phase_o <= 1'b0;
      calls_o <= 8'h00;
    end else begin
      cyc_reg <= cyc_reg + 2'h1;
      phase_o <= (cyc_reg == 2'h3);
      // only entry pushes, no own calls
      if (call_req_i && push_pc_i)
        calls_o <= calls_o + 8'h01;
    end
  end
endmodule

// [sim/timer_timebase_interrupt_ctrl_tb_top.sv]
// Testbench top: register access and interrupt entry scenarios
`include "intc_regs.vh"
module timer_timebase_interrupt_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam VARIANT = 0;
  logic        ref_clk, nrst, hsel, hwrite, ext_edge, tb_ovf, full, sleep;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  timer_ovf;
  logic [7:0]  vec, calls, pri, sec;
  logic [7:0]  vtab [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
  wire         hready, hresp, phase, call_req, push_pc, wake, irq;
  int          num_errors, n_checks;

  timer_timebase_interrupt_ctrl #(.VARIANT(VARIANT))
    timer_timebase_interrupt_ctrl_inst (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .ext_edge_i(ext_edge),
    .timer_ovf_i(timer_ovf), .timebase_ovf_i(tb_ovf),
    .third_clock_phase_i(phase), .stack_full_i(full),
    .core_sleep_i(sleep), .call_req_o(call_req), .call_vector_o(vec),
    .push_pc_o(push_pc), .wake_o(wake), .irq_o(irq));

  core_model core_model_inst (
    .clk_i(ref_clk), .nrst_i(nrst), .call_req_i(call_req),
    .push_pc_i(push_pc), .phase_o(phase), .calls_o(calls));

  // --------
  // Tasks
  // --------
  task check(input string name, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Leading edge leaves one idle cycle, so a read never sees a stale write
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge ref_clk);
    while (hready !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask

  task rdc(input string name, input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    check(name, rd, e);
  endtask

  task wait_call(input logic [7:0] e, input logic [31:0] np);
    logic [31:0] ph;
    ph = 32'h0000_0000;
    // Counts the take pulse plus the entry wait, up to the call
    for (int n = 0; n < 60 && call_req !== 1'b1; n++) begin
      @(posedge ref_clk);
      if (phase === 1'b1) begin
        ph = ph + 32'h0000_0001;
      end
    end
    check("call_req", 32'(call_req), 32'h0000_0001);
    check("vector", 32'(vec), 32'(e));
    check("phase pulses", ph, np);
  endtask

  task test_done();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // --------
  // Clock, watchdog, sequence
  // --------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Whole sequence needs under two microseconds
  initial begin
    #50us;
    num_errors++;
    test_done();
  end

  initial begin
    {nrst, hsel, hwrite, ext_edge, tb_ovf, full, sleep} = 7'h00;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    timer_ovf = 3'h0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdc("primary", `OFF_PRIMARY, 32'h0000_0000);
    rdc("secondary", `OFF_SECONDARY, 32'h0000_0000);
    rdc("unmapped", 8'h20, 32'h0000_0000);
    // Every source fires with only the master enable on
    ahb(1'b1, `OFF_PRIMARY, 32'h0000_0001);
    {ext_edge, timer_ovf, tb_ovf} <= 5'h1F;
    @(posedge ref_clk);
    {ext_edge, timer_ovf, tb_ovf} <= 5'h00;
    repeat (16) @(posedge ref_clk);
    check("calls", 32'(calls), 32'h0000_0000);
    rdc("primary", `OFF_PRIMARY, 32'h0000_0071);
    rdc("secondary", `OFF_SECONDARY, 32'h0000_0050);
    ahb(1'b1, `OFF_PRIMARY, 32'h0000_0000);
    rdc("primary", `OFF_PRIMARY, 32'h0000_0000);
    ahb(1'b1, `OFF_PRIMARY, 32'h0000_00FE);
    rdc("primary", `OFF_PRIMARY, 32'h0000_007E);
    ahb(1'b1, `OFF_SECONDARY, 32'h0000_00FF);
    rdc("secondary", `OFF_SECONDARY, 32'h0000_0055);
    pri = 8'h7E;
    sec = 8'h55;
    // All five pending: one call per master enable, in priority order
    for (int i = 0; i < 5; i++) begin
      ahb(1'b1, `OFF_PRIMARY, 32'(pri | 8'h01));
      wait_call(vtab[i], 32'h0000_0003);
      if (i < 3) pri[4 + i] = 1'b0;
      else sec[2 * i - 2] = 1'b0;
      rdc("primary", `OFF_PRIMARY, 32'(pri));
      rdc("secondary", `OFF_SECONDARY, 32'(sec));
    end
    check("pushes", 32'(calls), 32'h0000_0005);
    // Full stack stalls the entry and raises the stall event
    ahb(1'b1, `OFF_EVT_CLEAR, 32'h0000_0007);
    full <= 1'b1;
    ahb(1'b1, `OFF_PRIMARY, 32'h0000_0013);
    repeat (16) @(posedge ref_clk);
    check("calls", 32'(calls), 32'h0000_0005);
    rdc("events", `OFF_EVT_STATUS, 32'h0000_0002);
    rdc("core", `OFF_CORE_STAT, 32'h0000_0218);
    ahb(1'b1, `OFF_EVT_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    check("irq masked", 32'(irq), 32'h0000_0000);
    ahb(1'b1, `OFF_EVT_ENABLE, 32'h0000_0002);
    repeat (2) @(posedge ref_clk);
    check("irq", 32'(irq), 32'h0000_0001);
    full <= 1'b0;
    wait_call(8'h04, 32'h0000_0003);
    ahb(1'b1, `OFF_EVT_CLEAR, 32'h0000_0007);
    rdc("events", `OFF_EVT_STATUS, 32'h0000_0000);
    check("irq cleared", 32'(irq), 32'h0000_0000);
    // Sleeping core: wake without master enable, then woken entry
    sleep <= 1'b1;
    ahb(1'b1, `OFF_PRIMARY, 32'h0000_0012);
    repeat (2) @(posedge ref_clk);
    check("wake", 32'(wake), 32'h0000_0001);
    ahb(1'b1, `OFF_PRIMARY, 32'h0000_0013);
    wait_call(8'h04, 32'h0000_0004);
    sleep <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("wake idle", 32'(wake), 32'h0000_0000);
    test_done();
  end
endmodule

bind timer_timebase_interrupt_ctrl intc_properties #(.VARIANT(VARIANT))
  intc_properties_inst (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .third_clock_phase_i(third_clock_phase_i),
  .stack_full_i(stack_full_i), .core_sleep_i(core_sleep_i),
  .call_req_o(call_req_o), .call_vector_o(call_vector_o),
  .push_pc_o(push_pc_o), .wake_o(wake_o));
